//--- dv/bpt_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================================
// port checker for the brown-out sequencer
// ==================================================================
module bpt_monitor
  import bpt_pkg::*;
#(
  parameter int unsigned BOR_MIN_CYCLES = BOR_MIN_CYC,
  parameter int unsigned RC_TICK_CYCLES = RC_TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // inputs
  input wire logic supply_below_thr,
  input wire logic [1:0] brownout_mode_cfg,
  input wire logic [1:0] brownout_threshold_cfg,
  input wire logic powerup_delay_disable_n,
  input wire logic sleep_active,
  input wire logic avs_read,
  input wire logic avs_write,
  // outputs
  input wire logic device_reset_hold,
  input wire logic brownout_reset_active,
  input wire logic brownout_detect_on,
  input wire logic [1:0] brownout_threshold_sel,
  input wire logic avs_waitrequest
);
  localparam int DLY_MIN = 2048 * RC_TICK_CYCLES - 4;
  logic [31:0] low_cnt_ff;
  logic [31:0] hold_cnt_ff;

  // consecutive low cycles while detection is on
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_cnt_ff <= 32'h0000_0000;
    end else if (supply_below_thr && brownout_detect_on) begin
      low_cnt_ff <= low_cnt_ff + 32'h0000_0001;
    end else begin
      low_cnt_ff <= 32'h0000_0000;
    end
  end

  // length of the hold outside brown-out
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold_cnt_ff <= 32'h0000_0000;
    end else if (device_reset_hold && !brownout_reset_active) begin
      hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
    end else begin
      hold_cnt_ff <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence low_run;
    supply_below_thr [*3];
  endsequence
  sequence bor_left;
    $fell(brownout_reset_active);
  endsequence

  chk_bor_entry: assert property (low_cnt_ff == BOR_MIN_CYCLES + 4 |-> ##[0:6] brownout_reset_active)
    else $error("brown-out reset missing after long low supply");
  chk_bor_stays: assert property (low_run ##0 brownout_reset_active |=> brownout_reset_active)
    else $error("brown-out reset left while supply low");
  chk_bor_holds: assert property (brownout_reset_active |-> device_reset_hold)
    else $error("brown-out without device hold");
  chk_delay_hold: assert property (bor_left ##0 !powerup_delay_disable_n |-> device_reset_hold [*8])
    else $error("hold dropped at start of delay");
  chk_delay_length: assert property ($fell(device_reset_hold) && !powerup_delay_disable_n |-> hold_cnt_ff >= DLY_MIN)
    else $error("power-up delay too short");
  chk_skip_delay: assert property (bor_left ##0 powerup_delay_disable_n |-> ##[0:3] !device_reset_hold)
    else $error("hold kept with delay disabled");
  chk_mode_off: assert property ($past(brownout_mode_cfg) == MODE_OFF && $past(resetn) |-> !brownout_detect_on)
    else $error("detection on in off mode");
  chk_always_on: assert property ($past(brownout_mode_cfg) == MODE_HW_ON && $past(resetn) |-> brownout_detect_on)
    else $error("detection off in always-on mode");
  chk_sleep_off: assert property ($past(brownout_mode_cfg) == MODE_HW_SLEEP && $past(resetn)
    |-> brownout_detect_on == !$past(sleep_active))
    else $error("detection wrong around sleep");
  chk_thr_copy: assert property ($past(resetn) |-> brownout_threshold_sel == $past(brownout_threshold_cfg))
    else $error("threshold select differs from config");
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one wait");
endmodule

bind bpt_reset_ctrl bpt_monitor #(.BOR_MIN_CYCLES(BOR_MIN_CYCLES), .RC_TICK_CYCLES(RC_TICK_CYCLES)) u_monitor (
  .clk_sys(clk_sys), .resetn(resetn), .supply_below_thr(supply_below_thr),
  .brownout_mode_cfg(brownout_mode_cfg), .brownout_threshold_cfg(brownout_threshold_cfg),
  .powerup_delay_disable_n(powerup_delay_disable_n), .sleep_active(sleep_active),
  .avs_read(avs_read), .avs_write(avs_write), .device_reset_hold(device_reset_hold),
  .brownout_reset_active(brownout_reset_active), .brownout_detect_on(brownout_detect_on),
  .brownout_threshold_sel(brownout_threshold_sel), .avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================================
// self-checking bench for the brown-out sequencer
// ==================================================================
module testbench
  import bpt_pkg::*;
;
  localparam int MINC = 3;
  localparam int TICK = 2;
  localparam int DLY = 2048 * TICK - 16;
  logic clk_sys, resetn, supply_below_thr, powerup_delay_disable_n, sleep_active, avs_read, avs_write;
  logic [1:0] brownout_mode_cfg, brownout_threshold_cfg, brownout_threshold_sel;
  logic device_reset_hold, brownout_reset_active, brownout_detect_on, irq, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  int miscompares = 0;
  int tests_run = 0;

  bpt_reset_ctrl #(.BOR_MIN_CYCLES(MINC), .RC_TICK_CYCLES(TICK)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .supply_below_thr(supply_below_thr),
    .brownout_mode_cfg(brownout_mode_cfg), .brownout_threshold_cfg(brownout_threshold_cfg),
    .powerup_delay_disable_n(powerup_delay_disable_n), .sleep_active(sleep_active),
    .device_reset_hold(device_reset_hold), .brownout_reset_active(brownout_reset_active),
    .brownout_detect_on(brownout_detect_on), .brownout_threshold_sel(brownout_threshold_sel), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  // ================================================================
  // helpers
  // ================================================================
  // 50 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, e, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one avalon transfer until waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    cyc(1);
  endtask

  task automatic rdc(input string s, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(s, e, x);
  endtask

  task automatic wait_hold(output int n);
    n = 0;
    while (device_reset_hold === 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
  endtask

  // expected brown-out for a mode, software bit and sleep state
  function automatic logic det_exp(input logic [1:0] m, input logic s, input logic slp);
    return (m == MODE_SW && s) || (m == MODE_HW_SLEEP && !slp) || m == MODE_HW_ON;
  endfunction

  // expected reset control word, power-on flag set
  function automatic logic [31:0] exp_rc(input logic [1:0] m, input logic s, input logic b);
    return {25'h0, m == MODE_SW && s, 4'h0, 1'b1, b};
  endfunction

  // one brown-out attempt, random threshold and delay
  task automatic bor_try(input logic [1:0] m, input logic s, input logic slp);
    logic e, pd;
    logic [1:0] t;
    int n;
    logic [31:0] x;
    e = det_exp(m, s, slp);
    pd = 1'($urandom);
    t = 2'($urandom);
    brownout_mode_cfg <= m;
    sleep_active <= slp;
    brownout_threshold_cfg <= t;
    powerup_delay_disable_n <= pd;
    wr(OFS_RESET_CTRL, 32'h0000_0003 | {25'h0, s, 6'h0});
    bus(1'b0, OFS_STATUS, 32'h0000_0000, x);
    chk("status mode thr", {28'h0, m, t}, {28'h0, x[9:8], x[13:12]});
    chk("threshold sel", {30'h0, t}, {30'h0, brownout_threshold_sel});
    supply_below_thr <= 1'b1;
    cyc(MINC + 8 + int'($urandom_range(15)));
    chk("bor active", {31'h0, e}, {31'h0, brownout_reset_active});
    chk("irq", {31'h0, e}, {31'h0, irq});
    supply_below_thr <= 1'b0;
    n = 0;
    while (brownout_reset_active === 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    wait_hold(n);
    if (e) chk("delay skipped", {31'h0, pd}, {31'h0, n < 8});
    rdc("reset ctrl", OFS_RESET_CTRL, exp_rc(m, s, !e));
    wr(OFS_IRQ_STATUS, 32'h0000_0003);
  endtask

  // ================================================================
  // watchdog and main sequence
  // ================================================================
  initial begin
    cyc(60000);
    miscompares++;
    finish_test();
  end

  initial begin
    int n;
    resetn = 1'b0;
    supply_below_thr = 1'b0;
    brownout_mode_cfg = MODE_SW;
    brownout_threshold_cfg = 2'h0;
    powerup_delay_disable_n = 1'b0;
    sleep_active = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    void'($urandom(62999));
    cyc(16);
    resetn <= 1'b1;
    rdc("reset ctrl at power-on", OFS_RESET_CTRL, 32'h0000_0040);
    rdc("irq mask at power-on", OFS_IRQ_MASK, 32'h0000_0000);
    wait_hold(n);
    chk("power-on delay", 32'h0000_0001, {31'h0, n >= DLY && n <= DLY + 32});
    wr(4'h2, 32'hffff_ffff);
    rdc("unmapped", 4'h2, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      bor_try(2'(i >> 2), i[1], i[0]);
    end
    // glitch below the minimum duration
    brownout_mode_cfg <= MODE_HW_ON;
    powerup_delay_disable_n <= 1'b0;
    supply_below_thr <= 1'b1;
    cyc(2);
    supply_below_thr <= 1'b0;
    cyc(12);
    chk("glitch", 32'h0000_0000, {31'h0, brownout_reset_active});
    // drop in mid-delay restarts the full delay
    supply_below_thr <= 1'b1;
    cyc(MINC + 12);
    supply_below_thr <= 1'b0;
    cyc(1000);
    chk("hold in delay", 32'h0000_0001, {31'h0, device_reset_hold});
    supply_below_thr <= 1'b1;
    cyc(8);
    chk("bor again", 32'h0000_0001, {31'h0, brownout_reset_active});
    supply_below_thr <= 1'b0;
    cyc(8);
    wait_hold(n);
    chk("restarted delay", 32'h0000_0001, {31'h0, n >= DLY && n <= DLY + 32});
    // interrupt mask and clear
    chk("irq pending", 32'h0000_0001, {31'h0, irq});
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    avs_byteenable <= 4'he;
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    avs_byteenable <= 4'hf;
    rdc("irq mask lane", OFS_IRQ_MASK, 32'h0000_0003);
    wr(OFS_IRQ_STATUS, 32'h0000_0003);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rdc("irq status", OFS_IRQ_STATUS, 32'h0000_0000);
    // second power-on reset in mid-run
    powerup_delay_disable_n <= 1'b1;
    resetn <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
    rdc("reset ctrl after reset", OFS_RESET_CTRL, 32'h0000_0000);
    chk("hold skipped", 32'h0000_0000, {31'h0, device_reset_hold});
    finish_test();
  end
endmodule
`default_nettype wire

//--- inc/bpt_pkg.sv
// ==================================================================
// shared constants for the brown-out and power-up timer block
// ==================================================================
package bpt_pkg;

  // ================================================================
  // timing
  // ================================================================
  // system clock period
  localparam int unsigned CLK_PERIOD_NS = 20;
  // internal rc oscillator period, one power-up timer tick
  localparam int unsigned RC_PERIOD_NS = 32_000;
  // tick spacing in system clocks
  localparam int unsigned RC_TICK_CYC = RC_PERIOD_NS / CLK_PERIOD_NS;
  // power-up timer counter width, 2048 ticks
  localparam int unsigned POWERUP_DELAY_TIMER_BITS = 11;
  // least time the supply must stay low before reset
  localparam int unsigned BOR_MIN_NS = 1_000;
  // least time rounds up to whole clocks
  localparam int unsigned BOR_MIN_CYC = (BOR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ================================================================
  // register map, byte addresses
  // ================================================================
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_RESET_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hc;

  // reset_control_reg fields
  localparam int unsigned SW_EN_BIT = 6;
  localparam int unsigned POR_FLAG_BIT = 1;
  localparam int unsigned BOR_FLAG_BIT = 0;
  localparam logic SW_EN_RST = 1'h1;
  localparam logic POR_FLAG_RST = 1'h0;
  localparam logic BOR_FLAG_RST = 1'h0;

  // status register fields
  localparam int unsigned ST_HOLD_BIT = 0;
  localparam int unsigned ST_INBOR_BIT = 1;
  localparam int unsigned ST_TMR_BIT = 2;
  localparam int unsigned ST_DET_BIT = 3;
  localparam int unsigned ST_LOW_BIT = 4;
  localparam int unsigned ST_POWERUP_DELAY_TIMER_EN_BIT = 5;
  localparam int unsigned ST_MODE_LSB = 8;
  localparam int unsigned ST_THR_LSB = 12;

  // interrupt bits
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_BOR_BIT = 0;
  localparam int unsigned IRQ_REL_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // ================================================================
  // brown-out modes
  // ================================================================
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_HW_SLEEP = 2'h2;
  localparam logic [1:0] MODE_HW_ON = 2'h3;

  // sequencer states
  typedef enum logic [1:0] {ST_POR, ST_RUN, ST_BOR, ST_POWERUP_DELAY_TIMER} bpt_state_t;

endpackage

//--- inc/bpt_timer_if.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================================
// link between sequencer and power-up timer
// ==================================================================
interface bpt_timer_if import bpt_pkg::*; ();
  logic restart;
  logic run;
  logic done;
  logic [POWERUP_DELAY_TIMER_BITS-1:0] count;
  modport ctrl (output restart, output run, input done, input count);
  modport timer (input restart, input run, output done, output count);
endinterface
`default_nettype wire

//--- src/bpt_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================================
// brown-out reset and power-up delay sequencer
// ==================================================================
// Behaviour
// - with detection on, supply low beyond minimum duration resets the device
// - brown-out reset stays while the supply remains low
// - power-up timer starts when supply recovers, reset held until it ends
// - supply low during the delay returns to brown-out and restarts the timer
// - brown-out and power-up delay are configured independently
// - mode 01: software enable bit 6 turns detection on or fully off
// - other modes ignore the software enable bit, it reads zero
// - threshold comes only from the threshold configuration field
// - brown-out flag cleared on every brown-out and power-on reset
// - mode 10: detection off in sleep, back on when sleep ends
// - mode 11: detection always on, no software way to stop it
// - power-up timer is an 11-bit counter on the rc clock, 2048 ticks
// - reset held while the timer counts, released on terminal count
// - timer used when its active-low enable is clear, skipped when set
// - power-on flag bit 1 cleared on power-on, written to either value by software
// - software enable resets to one in mode 01 on power-on, else zero
module bpt_reset_ctrl
  import bpt_pkg::*;
#(
  parameter int unsigned BOR_MIN_CYCLES = BOR_MIN_CYC,
  parameter int unsigned RC_TICK_CYCLES = RC_TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // comparator, configuration and power state
  input wire logic supply_below_thr,
  input wire logic [1:0] brownout_mode_cfg,
  input wire logic [1:0] brownout_threshold_cfg,
  input wire logic powerup_delay_disable_n,
  input wire logic sleep_active,
  // reset and comparator control
  output logic device_reset_hold,
  output logic brownout_reset_active,
  output logic brownout_detect_on,
  output logic [1:0] brownout_threshold_sel,
  output logic irq,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int unsigned QUAL_W = $clog2(BOR_MIN_CYCLES + 1);

  // ================================================================
  // elaboration checks
  // ================================================================
  if (BOR_MIN_CYCLES < 1) begin : g_bad_min
    $error("brown-out minimum must be at least one clock");
  end
  if (RC_TICK_CYCLES < 1) begin : g_bad_tick
    $error("rc tick spacing must be at least one clock");
  end

  // ================================================================
  // functions
  // ================================================================
  // software enable as seen by logic and by reads
  function automatic logic sw_view(input logic [1:0] mode, input logic sw_en);
    sw_view = (mode == MODE_SW) && sw_en;
  endfunction

  // detector enable per mode
  function automatic logic detect_enabled(input logic [1:0] mode, input logic sw_en,
                                          input logic sleeping);
    logic on;
    on = 1'b0;
    unique case (mode)
      MODE_OFF: on = 1'b0;
      MODE_SW: on = sw_view(mode, sw_en);
      MODE_HW_SLEEP: on = !sleeping;
      MODE_HW_ON: on = 1'b1;
    endcase
    detect_enabled = on;
  endfunction

  // ================================================================
  // declarations
  // ================================================================
  bpt_timer_if tmr ();

  logic below_meta_ff;
  logic below_sync_ff;
  logic [QUAL_W-1:0] qual_cnt_ff;
  bpt_state_t state_ff;
  bpt_state_t nxt_state;
  logic sw_en_ff;
  logic por_seen_ff;
  logic por_flag_ff;
  logic bor_flag_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] nxt_irq_stat;
  logic hold_ff;
  logic in_bor_ff;
  logic detect_ff;
  logic [1:0] thr_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic detect_now;
  logic powerup_delay_timer_enabled;
  logic bor_trigger;
  logic bor_entry;
  logic release_evt;
  logic timer_restart;
  logic timer_run;
  logic req;
  logic wr_fire;
  logic wr_byte0;
  logic [31:0] rd_word;

  // ================================================================
  // power-up timer
  // ================================================================
  bpt_timer #(
    .TICK_CYCLES(RC_TICK_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tmr(tmr.timer)
  );

  assign tmr.restart = timer_restart;
  assign tmr.run = timer_run;

  // ================================================================
  // supply comparator input
  // ================================================================
  // two-flop synchroniser
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      below_meta_ff <= 1'b0;
      below_sync_ff <= 1'b0;
    end else begin
      below_meta_ff <= supply_below_thr;
      below_sync_ff <= below_meta_ff;
    end
  end

  // detector enable and delay enable
  assign detect_now = detect_enabled(brownout_mode_cfg, sw_en_ff, sleep_active);
  assign powerup_delay_timer_enabled = !powerup_delay_disable_n;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      qual_cnt_ff <= '0;
    end else if (state_ff != ST_RUN || !detect_now || !below_sync_ff) begin
      qual_cnt_ff <= '0;
    end else if (qual_cnt_ff != QUAL_W'(BOR_MIN_CYCLES)) begin
      qual_cnt_ff <= qual_cnt_ff + 1'b1;
    end
  end

  // low for longer than the minimum
  assign bor_trigger = detect_now && below_sync_ff && (qual_cnt_ff == QUAL_W'(BOR_MIN_CYCLES));

  // ================================================================
  // reset sequencer
  // ================================================================
  // next state and timer control
  always_comb begin
    nxt_state = state_ff;
    timer_restart = 1'b0;
    timer_run = 1'b0;
    unique case (state_ff)
      ST_POR: begin
        timer_restart = 1'b1;
        nxt_state = powerup_delay_timer_enabled ? ST_POWERUP_DELAY_TIMER : ST_RUN;
      end
      ST_RUN: begin
        if (bor_trigger) begin
          nxt_state = ST_BOR;
        end
      end
      ST_BOR: begin
        timer_restart = 1'b1;
        if (!below_sync_ff) begin
          nxt_state = powerup_delay_timer_enabled ? ST_POWERUP_DELAY_TIMER : ST_RUN;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        timer_run = 1'b1;
        if (detect_now && below_sync_ff) begin
          nxt_state = ST_BOR;
          timer_restart = 1'b1;
        end else if (tmr.done) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_POR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // sequencer events
  assign bor_entry = (state_ff != ST_BOR) && (nxt_state == ST_BOR);
  assign release_evt = (state_ff != ST_RUN) && (nxt_state == ST_RUN);

  // registered reset hold and state outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold_ff <= 1'b1;
      in_bor_ff <= 1'b0;
    end else begin
      hold_ff <= (nxt_state != ST_RUN);
      in_bor_ff <= (nxt_state == ST_BOR);
    end
  end

  // comparator control outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      detect_ff <= 1'b0;
      thr_ff <= 2'h0;
    end else begin
      detect_ff <= detect_now;
      thr_ff <= brownout_threshold_cfg;
    end
  end

  assign device_reset_hold = hold_ff;
  assign brownout_reset_active = in_bor_ff;
  assign brownout_detect_on = detect_ff;
  assign brownout_threshold_sel = thr_ff;

  // ================================================================
  // avalon slave
  // ================================================================
  // one wait cycle per access
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_ff;
  assign wr_fire = avs_write && ack_ff;
  assign wr_byte0 = wr_fire && avs_byteenable[0];

  // access phase
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (avs_address)
      OFS_RESET_CTRL: begin
        rd_word[SW_EN_BIT] = sw_view(brownout_mode_cfg, sw_en_ff);
        rd_word[POR_FLAG_BIT] = por_flag_ff;
        rd_word[BOR_FLAG_BIT] = bor_flag_ff;
      end
      OFS_STATUS: begin
        rd_word[ST_HOLD_BIT] = hold_ff;
        rd_word[ST_INBOR_BIT] = in_bor_ff;
        rd_word[ST_TMR_BIT] = (state_ff == ST_POWERUP_DELAY_TIMER);
        rd_word[ST_DET_BIT] = detect_ff;
        rd_word[ST_LOW_BIT] = below_sync_ff;
        rd_word[ST_POWERUP_DELAY_TIMER_EN_BIT] = powerup_delay_timer_enabled;
        rd_word[ST_MODE_LSB +: 2] = brownout_mode_cfg;
        rd_word[ST_THR_LSB +: 2] = thr_ff;
      end
      OFS_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_stat_ff;
      OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_ff;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= rd_word;
    end
  end

  assign avs_readdata = rdata_ff;

  // ================================================================
  // reset_control_reg bits
  // ================================================================
  // first clock after power-on release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      por_seen_ff <= 1'b0;
    end else begin
      por_seen_ff <= 1'b1;
    end
  end

  // software enable, kept over brown-out resets
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sw_en_ff <= SW_EN_RST;
    end else if (!por_seen_ff && brownout_mode_cfg != MODE_SW) begin
      sw_en_ff <= 1'b0;
    end else if (wr_byte0 && avs_address == OFS_RESET_CTRL && brownout_mode_cfg == MODE_SW) begin
      sw_en_ff <= avs_writedata[SW_EN_BIT];
    end
  end

  // power-on flag, cleared by power-on, software writes either value
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      por_flag_ff <= POR_FLAG_RST;
    end else if (wr_byte0 && avs_address == OFS_RESET_CTRL) begin
      por_flag_ff <= avs_writedata[POR_FLAG_BIT];
    end
  end

  // brown-out flag, hardware clear beats software set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bor_flag_ff <= BOR_FLAG_RST;
    end else if (bor_entry) begin
      bor_flag_ff <= 1'b0;
    end else if (wr_byte0 && avs_address == OFS_RESET_CTRL) begin
      bor_flag_ff <= avs_writedata[BOR_FLAG_BIT];
    end
  end

  // ================================================================
  // interrupts
  // ================================================================
  // sticky events, set wins over write-one clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_byte0 && avs_address == OFS_IRQ_STATUS) begin
      nxt_irq_stat = nxt_irq_stat & ~avs_writedata[IRQ_W-1:0];
    end
    if (bor_entry) begin
      nxt_irq_stat[IRQ_BOR_BIT] = 1'b1;
    end
    if (release_evt) begin
      nxt_irq_stat[IRQ_REL_BIT] = 1'b1;
    end
  end

  // status and mask registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_byte0 && avs_address == OFS_IRQ_MASK) begin
        irq_mask_ff <= avs_writedata[IRQ_W-1:0];
      end
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule
`default_nettype wire

//--- src/bpt_timer.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================================
// power-up delay timer on rc tick enables
// ==================================================================
module bpt_timer
  import bpt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = RC_TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // sequencer side
  bpt_timer_if.timer tmr
);
  localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("tick spacing must be at least one clock");
  end

  logic [DIV_W-1:0] div_ff;
  logic [POWERUP_DELAY_TIMER_BITS-1:0] cnt_ff;
  logic done_ff;
  logic tick;
  logic active;

  // one-cycle internal_rc_clock enable
  assign tick = (div_ff == DIV_W'(TICK_CYCLES - 1));
  assign active = tmr.run && !done_ff;

  // rc divider
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_ff <= '0;
    end else if (tmr.restart || !active || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (tmr.restart) begin
      cnt_ff <= '0;
    end else if (active && tick) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else if (tmr.restart) begin
      done_ff <= 1'b0;
    end else if (active && tick && (&cnt_ff)) begin
      done_ff <= 1'b1;
    end
  end

  assign tmr.done = done_ff;
  assign tmr.count = cnt_ff;
endmodule
`default_nettype wire
